// File: hdl/lfsirq_regs.sv
// led short fault config and supply fault irq enable registers
`timescale 1ns/1ns
`default_nettype none
module lfsirq_regs
    import lfsirq_pkg::*;
#(
    parameter int NUM_STR = LFSIRQ_NUM_STR,
    parameter int NUM_IRQ = LFSIRQ_NUM_IRQ
)
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [NUM_IRQ-1:0] fault_in,
    output logic string_ground_short_detect_on,
    output logic [NUM_STR-1:0] string_short_fault_off,
    output logic [NUM_IRQ-1:0] irq_on,
    output logic [NUM_IRQ-1:0] fault_irq,
    output logic supply_irq
);
    // the register layouts are fixed at six strings and six fault enables
    generate
        if (NUM_STR != LFSIRQ_NUM_STR) begin : g_chk_str
            $error("string count must match register layout");
        end
        if (NUM_IRQ != LFSIRQ_NUM_IRQ) begin : g_chk_irq
            $error("irq count must match register layout");
        end
    endgenerate

    typedef struct packed {
        logic [15:0] cfg;
        logic [1:0] sup_rsv;
        logic [NUM_IRQ-1:0] flt_s1;
        logic [NUM_IRQ-1:0] flt_s2;
        logic [NUM_IRQ-1:0] irq;
        logic irq_any;
        logic [15:0] rdata;
        logic rvalid;
    } lfsirq_top_st_t;

    lfsirq_top_st_t st_r;
    lfsirq_top_st_t st_nxt;

    logic [NUM_IRQ-1:0] en;
    logic sync_en;
    logic wr_cfg;
    logic wr_sup;

    // address match, shared by write and read decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    // read view of one enable field
    function automatic logic [1:0] rd_code(input logic on);
        rd_code = on ? LFSIRQ_RD_ON : LFSIRQ_RD_OFF; // [RQ4]
    endfunction

    // write strobes per register
    assign wr_cfg = reg_wr && hit(reg_addr, LFSIRQ_ADDR_CFG);
    assign wr_sup = reg_wr && hit(reg_addr, LFSIRQ_ADDR_SUP);

    // one enable cell per supply fault; field i sits at bits 2i+1..2i
    // index 0 input undervoltage [RQ12], 1 input overvoltage [RQ11]
    // index 2 logic supply low [RQ10], 3 input overcurrent [RQ9]
    // index 4 pump capacitor loss [RQ8], 5 pump fault [RQ7]
    // every cell resets to enabled, so each field reads 2h after reset
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IRQ; gi++) begin : g_field
            lfsirq_irq_field u_field (
                .mclk(mclk),
                .srst(srst),
                .ce(ce),
                .wr(wr_sup),
                .wdata(reg_wdata[LFSIRQ_FIELD_W*gi +: LFSIRQ_FIELD_W]),
                .en(en[gi])
            );
        end
    endgenerate

    // sync clock loss enable at 13-12 is a cell of its own [RQ6]
    // no fault input for it here, so it only shows in the read view;
    // keeping it out of irq_on leaves the port widths as they are
    lfsirq_irq_field u_sync_field (
        .mclk(mclk),
        .srst(srst),
        .ce(ce),
        .wr(wr_sup),
        .wdata(reg_wdata[LFSIRQ_SYNC_LSB +: LFSIRQ_FIELD_W]),
        .en(sync_en)
    );

    // next state: register writes, fault sync, gating and read data
    always_comb begin
        logic [15:0] sup_view;
        sup_view = 16'h0000;
        st_nxt = st_r;

        // config register keeps all bits as written, reserved ones too
        if (wr_cfg) begin
            st_nxt.cfg = reg_wdata; // [RQ1] [RQ3]
        end
        if (wr_sup) begin
            st_nxt.sup_rsv = reg_wdata[LFSIRQ_SUP_RSV_LSB +: 2];
        end

        // two flops before any logic looks at the comparator levels
        st_nxt.flt_s1 = fault_in;
        st_nxt.flt_s2 = st_r.flt_s1;

        // a fault reaches the host only while its enable is on
        st_nxt.irq = st_r.flt_s2 & en; // [RQ14]
        st_nxt.irq_any = |(st_r.flt_s2 & en); // [RQ14]

        // assemble the supply register read view
        sup_view[LFSIRQ_SUP_RSV_LSB +: 2] = st_r.sup_rsv;
        for (int i = 0; i < NUM_IRQ; i++) begin
            sup_view[LFSIRQ_FIELD_W*i +: LFSIRQ_FIELD_W] = rd_code(en[i]);
        end
        // sync clock loss field sits above the six fault fields [RQ6]
        sup_view[LFSIRQ_SYNC_LSB +: LFSIRQ_FIELD_W] = rd_code(sync_en);

        // read data one cycle after the strobe; unmapped reads give zero
        st_nxt.rvalid = reg_rd;
        if (reg_rd) begin
            if (hit(reg_addr, LFSIRQ_ADDR_CFG)) begin
                st_nxt.rdata = st_r.cfg;
            end else if (hit(reg_addr, LFSIRQ_ADDR_SUP)) begin
                st_nxt.rdata = sup_view; // [RQ4]
            end else begin
                st_nxt.rdata = 16'h0000;
            end
        end
    end

    // state register; ce low freezes everything including the syncs
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_r.cfg <= LFSIRQ_CFG_RST; // [RQ1] [RQ3]
            st_r.sup_rsv <= LFSIRQ_SUP_RST[LFSIRQ_SUP_RSV_LSB +: 2];
            st_r.flt_s1 <= '0;
            st_r.flt_s2 <= '0;
            st_r.irq <= '0;
            st_r.irq_any <= 1'b0;
            st_r.rdata <= 16'h0000;
            st_r.rvalid <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from state flops
    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign string_ground_short_detect_on = st_r.cfg[LFSIRQ_GND_DET_BIT];
    assign string_short_fault_off = st_r.cfg[LFSIRQ_STR_LSB +: NUM_STR];
    assign irq_on = en;
    assign fault_irq = st_r.irq;
    assign supply_irq = st_r.irq_any;
endmodule
`default_nettype wire

// File: hdl/lfsirq_pkg.sv
// constants and field layout of the led fault config and supply irq registers
// How it works
// RQ1: bit 8 enables ground short detection, reset 1
// RQ2: host writes zero to config bits 7-6
// RQ3: bits 0-5 suppress per-string short fault
// RQ4: enable field reads 0h off, 2h on
// RQ5: write 1h disables, 3h enables interrupt
// RQ6: bits 13-12 sync clock loss enable, on
// RQ7: bits 11-10 pump fault enable, reset on
// RQ8: bits 9-8 pump capacitor loss enable, on
// RQ9: bits 7-6 input overcurrent enable, reset on
// RQ10: bits 5-4 logic supply low enable, on
// RQ11: bits 3-2 input overvoltage enable, reset on
// RQ12: bits 1-0 input undervoltage enable, reset on
// RQ13: writing 0h or 2h leaves enable unchanged
// RQ14: fault interrupts only while enable reads on
package lfsirq_pkg;

    // register addresses on the decoded serial access port
    localparam logic [7:0] LFSIRQ_ADDR_CFG = 8'h06;
    localparam logic [7:0] LFSIRQ_ADDR_SUP = 8'h08;

    // reset values
    localparam logic [15:0] LFSIRQ_CFG_RST = 16'h0100;
    localparam logic [15:0] LFSIRQ_SUP_RST = 16'h2aaa;
    localparam logic LFSIRQ_FIELD_RST = 1'b1;

    // first configuration register layout
    localparam int LFSIRQ_GND_DET_BIT = 8;
    localparam int LFSIRQ_STR_LSB = 0;
    localparam int LFSIRQ_NUM_STR = 6;

    // supply irq register layout: field i at bits 2i+1..2i
    localparam int LFSIRQ_NUM_IRQ = 6;
    localparam int LFSIRQ_FIELD_W = 2;
    localparam int LFSIRQ_SUP_RSV_LSB = 14;
    localparam int LFSIRQ_SYNC_LSB = 12;
    localparam int LFSIRQ_IDX_VIN_UV = 0;
    localparam int LFSIRQ_IDX_VIN_OV = 1;
    localparam int LFSIRQ_IDX_VDD_UV = 2;
    localparam int LFSIRQ_IDX_VIN_OC = 3;
    localparam int LFSIRQ_IDX_CP_CAP = 4;
    localparam int LFSIRQ_IDX_CP = 5;

    // split encodings of an enable field
    localparam logic [1:0] LFSIRQ_RD_OFF = 2'h0;
    localparam logic [1:0] LFSIRQ_RD_ON = 2'h2;
    localparam logic [1:0] LFSIRQ_WR_OFF = 2'h1;
    localparam logic [1:0] LFSIRQ_WR_ON = 2'h3;

    // synchroniser depth for fault comparator inputs
    localparam int LFSIRQ_SYNC_STAGES = 2;

endpackage

// File: hdl/lfsirq_irq_field.sv
// one interrupt enable with split read and write encodings
`timescale 1ns/1ns
`default_nettype none
module lfsirq_irq_field
    import lfsirq_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire logic wr,
    input wire logic [1:0] wdata,
    output logic en
);
    typedef struct packed {
        logic on;
    } lfsirq_fld_st_t;

    lfsirq_fld_st_t st_r;
    lfsirq_fld_st_t st_nxt;

    // only the two command codes act; the read codes are harmless to echo
    always_comb begin
        st_nxt = st_r;
        if (wr) begin
            if (wdata == LFSIRQ_WR_OFF) begin
                st_nxt.on = 1'b0; // [RQ5]
            end else if (wdata == LFSIRQ_WR_ON) begin
                st_nxt.on = 1'b1; // [RQ5]
            end
            // 0h and 2h fall through and keep the state [RQ13]
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_r.on <= LFSIRQ_FIELD_RST;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign en = st_r.on;
endmodule
`default_nettype wire

// File: tb/lfsirq_regs_checker.sv
// assertions on the register block ports
`timescale 1ns/1ns
`default_nettype none
module lfsirq_regs_checker #(
    parameter int NUM_STR = 6,
    parameter int NUM_IRQ = 6
)
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic string_ground_short_detect_on,
    input wire logic [NUM_STR-1:0] string_short_fault_off,
    input wire logic [NUM_IRQ-1:0] irq_on,
    input wire logic [NUM_IRQ-1:0] fault_irq,
    input wire logic supply_irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    // accepted writes to each register
    wire logic wc = ce && reg_wr && reg_addr == 8'h06;
    wire logic ws = ce && reg_wr && reg_addr == 8'h08;
    a_rd_answer:
        assert property (ce && reg_rd |=> reg_rvalid) else $error("rvalid");
    a_det_write:
        assert property (wc |=> string_ground_short_detect_on ==
            $past(reg_wdata[8])) else $error("detect bit");
    a_str_write:
        assert property (wc |=> string_short_fault_off ==
            $past(reg_wdata[5:0])) else $error("string bits");
    a_off_write:
        assert property (ws && reg_wdata[1:0] == 2'h1 |=> !irq_on[0])
        else $error("field 0 off");
    a_on_write:
        assert property (ws && reg_wdata[11:10] == 2'h3 |=> irq_on[5])
        else $error("field 5 on");
    a_keep_state:
        assert property (ws && !reg_wdata[6] |=> $stable(irq_on[3]))
        else $error("field 3 moved");
    a_rd_view:
        assert property (ce && reg_rd && reg_addr == 8'h08 |=>
            reg_rdata[9:8] == {$past(irq_on[4]), 1'b0}) else $error("view");
    a_rd_codes:
        assert property (ce && reg_rd && reg_addr == 8'h08 |=>
            (reg_rdata & 16'h1555) == 16'h0000) else $error("read code");
    // a frozen edge keeps the old gated level, so only check after a live one
    a_irq_gate:
        assert property ($past(ce) |-> (fault_irq & ~$past(irq_on)) == '0)
        else $error("ungated irq");
    a_irq_any:
        assert property (supply_irq == |fault_irq) else $error("summary irq");
endmodule
bind lfsirq_regs lfsirq_regs_checker #(
    .NUM_STR(NUM_STR),
    .NUM_IRQ(NUM_IRQ)
) chk_i (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .string_ground_short_detect_on(string_ground_short_detect_on),
    .string_short_fault_off(string_short_fault_off),
    .irq_on(irq_on),
    .fault_irq(fault_irq),
    .supply_irq(supply_irq)
);
`default_nettype wire

// File: tb/lfsirq_host.sv
// host model on the decoded register port
`timescale 1ns/1ns
`default_nettype none
module lfsirq_host (
    input wire logic mclk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    // one access, held for one clock; idle bus shows inverted last values
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [15:0] d, output logic [15:0] q);
        @(posedge mclk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= (a == 8'h06) ? d & 16'hff3f : d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        @(posedge mclk);
        q = reg_rvalid ? reg_rdata : 16'hxxxx;
    endtask
endmodule
`default_nettype wire

// File: tb/lfsirq_regs_tb.sv
// self-checking bench for the fault config and irq enable registers
`timescale 1ns/1ns
`default_nettype none
module lfsirq_regs_tb;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [5:0] fault_in = 6'h00;
    logic reg_wr, reg_rd, reg_rvalid, supply_irq;
    logic string_ground_short_detect_on;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, q;
    logic [5:0] string_short_fault_off, irq_on, fault_irq;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #10 mclk = ~mclk;
    lfsirq_regs uut (
        .mclk(mclk),
        .srst(srst),
        .ce(ce),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .fault_in(fault_in),
        .string_ground_short_detect_on(string_ground_short_detect_on),
        .string_short_fault_off(string_short_fault_off),
        .irq_on(irq_on),
        .fault_irq(fault_irq),
        .supply_irq(supply_irq)
    );
    lfsirq_host host (
        .mclk(mclk),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid)
    );
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [15:0] d);
        host.acc(1'b1, a, d, q);
    endtask
    task automatic rd(logic [7:0] a, logic [15:0] e);
        host.acc(1'b0, a, 16'h0000, q);
        chk("rdata", q, e);
    endtask
    // hang guard, far above the 140 or so cycles needed
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd(8'h06, 16'h0100);
        rd(8'h08, 16'h2aaa);
        rd(8'h07, 16'h0000);
        $display("test reset done");
        // config bits written both ways
        wr(8'h06, 16'hffff);
        rd(8'h06, 16'hff3f);
        chk("str", 16'(string_short_fault_off), 16'h003f);
        wr(8'h06, 16'h0000);
        chk("det", 16'(string_ground_short_detect_on), 16'h0000);
        $display("test config done");
        // each field off alone, then on again, to pin its position
        for (int i = 0; i < 7; i++) begin
            wr(8'h08, 16'h1 << 2 * i);
            rd(8'h08, 16'h2aaa & ~(16'h3 << 2 * i));
            wr(8'h08, 16'h3 << 2 * i);
            rd(8'h08, 16'h2aaa);
        end
        wr(8'h08, 16'h5555);
        rd(8'h08, 16'h4000);
        wr(8'h08, 16'haaaa);
        rd(8'h08, 16'h8000);
        $display("test fields done");
        // all faults raised with every enable off after the aaaa write, then two written on
        fault_in <= 6'h3f;
        repeat (4) @(posedge mclk);
        chk("irq", 16'(fault_irq), 16'h0000);
        wr(8'h08, 16'h0c03);
        repeat (2) @(posedge mclk);
        chk("irq", 16'(fault_irq), 16'h0021);
        chk("sup", 16'(supply_irq), 16'h0001);
        chk("on", 16'(irq_on), 16'h0021);
        // frozen clock enable swallows a write
        ce <= 1'b0;
        wr(8'h06, 16'h0001);
        ce <= 1'b1;
        rd(8'h06, 16'h0000);
        $display("test faults done");
        // second reset in mid-run, faults still raised
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd(8'h06, 16'h0100);
        rd(8'h08, 16'h2aaa);
        chk("on", 16'(irq_on), 16'h003f);
        chk("irq", 16'(fault_irq), 16'h003f);
        $display("test reset again done");
        final_report();
    end
endmodule
`default_nettype wire
